// >>> core/irq_enable_bank.sv
// One word of interrupt enable flip-flops with write-one set and clear
`timescale 1ns/1ps
module irq_enable_bank
	import irq_enable_pkg::*;
#(
	parameter int unsigned W = 32 // Bits in this word
) (
	input  wire logic ref_clk_i,  // Core clock
	input  wire logic resetn_i,   // Synchronous reset, active low
	irq_word_if.bank  word        // Masks in, enable state out
);

	// Whole state of the word
	typedef struct packed {
		logic [W-1:0] en; // Enable bit per interrupt
	} bank_state_s;

	bank_state_s state_q; // Registered state
	bank_state_s state_d; // Next state

	// Set wins over clear, so an enable racing a disable is never lost
	always_comb begin
		state_d    = state_q;
		state_d.en = (state_q.en & ~word.clear_bits)
		             | word.set_bits;
	end

	// Register the state; every interrupt starts disabled
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			state_q.en <= ENABLE_RST[W-1:0];
		end else begin
			state_q <= state_d;
		end
	end

	assign word.enable = state_q.en;

endmodule : irq_enable_bank

// >>> core/irq_enable_pkg.sv
// Package with register map and widths for the interrupt enable block
package irq_enable_pkg;

	localparam int unsigned ADDR_W    = 8;   // Register address width
	localparam int unsigned DATA_W    = 32;  // Register data width
	localparam int unsigned NUM_IRQ   = 79;  // Interrupts 0 to 78
	localparam int unsigned WORD_BITS = 32;  // Enable bits per word
	localparam int unsigned NUM_WORDS = 3;   // Words per register kind
	localparam int unsigned IDX_W     = 2;   // Width of a word index

	// Byte addresses of the six enable words
	localparam logic [ADDR_W-1:0] OFS_SET_WORD1 = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_SET_WORD2 = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_SET_WORD3 = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CLR_WORD1 = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_CLR_WORD2 = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_CLR_WORD3 = 8'h18;

	localparam logic [ADDR_W-1:0] WORD_STRIDE = 8'h04; // Bytes between words
	localparam logic [DATA_W-1:0] RDATA_IDLE  = 32'h00000000; // Idle/unmapped read
	localparam logic [DATA_W-1:0] ENABLE_RST  = 32'h00000000; // Enable reset value

	// Result of decoding one bus address
	typedef struct packed {
		logic             hit;      // Address names an enable word
		logic             is_clear; // Clear word rather than set word
		logic [IDX_W-1:0] idx;      // Word index 0..2
	} addr_dec_s;

endpackage : irq_enable_pkg

// >>> core/irq_enable_regs.sv
// Interrupt enable set/clear register block with its register port
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module irq_enable_regs
	import irq_enable_pkg::*;
(
	input  wire logic              ref_clk_i,   // Core clock, 25 MHz
	input  wire logic              resetn_i,    // Synchronous reset, active low
	input  wire logic [ADDR_W-1:0] addr_i,      // Register byte address
	input  wire logic [DATA_W-1:0] wdata_i,     // Write data
	input  wire logic              wr_i,        // Write strobe, one cycle
	input  wire logic              rd_i,        // Read strobe, one cycle
	output logic      [DATA_W-1:0] rdata_o,     // Read data, cycle after rd_i
	output logic     [NUM_IRQ-1:0] irq_enable_o // Enable state per interrupt
);

	// Decode an address into word kind and index; used for reads and writes
	function automatic addr_dec_s decode(input logic [ADDR_W-1:0] a);
		addr_dec_s r;
		r          = '0;
		r.hit      = 1'b1;
		unique case (a)
			OFS_SET_WORD1: r.idx = 2'h0;
			OFS_SET_WORD2: r.idx = 2'h1;
			OFS_SET_WORD3: r.idx = 2'h2;
			OFS_CLR_WORD1: begin
				r.idx      = 2'h0;
				r.is_clear = 1'b1;
			end
			OFS_CLR_WORD2: begin
				r.idx      = 2'h1;
				r.is_clear = 1'b1;
			end
			OFS_CLR_WORD3: begin
				r.idx      = 2'h2;
				r.is_clear = 1'b1;
			end
			default: r.hit = 1'b0; // Unmapped: reads zero, writes dropped
		endcase
		return r;
	endfunction : decode

	addr_dec_s                   dec;             // Decode of this cycle's address
	logic [NUM_WORDS*WORD_BITS-1:0] enable_flat;   // All words, zero padded
	logic [DATA_W-1:0]           word_rd [NUM_WORDS]; // Per word read view

	// One decode feeds both the write masks and the read mux
	assign dec = decode(addr_i);

	// One enable bank per word; the last word holds only the upper interrupts
	for (genvar g = 0; g < NUM_WORDS; g++) begin : g_word
		localparam int unsigned W = (g == NUM_WORDS - 1) ?
		                            NUM_IRQ - g * WORD_BITS : WORD_BITS;
		irq_word_if #(.W(W)) word_bus ();
		logic hit_word; // Write strobe aimed at this index

		assign hit_word = wr_i && dec.hit && (dec.idx == IDX_W'(g));
		// Masks last one cycle; the bank alone holds the enable state
		// Only a written one moves a bit; zeros produce an empty mask
		assign word_bus.set_bits   = (hit_word && !dec.is_clear) ?
		                             wdata_i[W-1:0] : '0;
		assign word_bus.clear_bits = (hit_word && dec.is_clear) ?
		                             wdata_i[W-1:0] : '0;

		irq_enable_bank #(.W(W)) u_bank (
			.ref_clk_i (ref_clk_i),
			.resetn_i  (resetn_i),
			.word      (word_bus)
		);

		// Unused upper bits of the short word read as zero; the cast pads
		// with zeros, so a full word needs no empty replication
		assign enable_flat[g*WORD_BITS +: WORD_BITS] =
		       WORD_BITS'(word_bus.enable);
		assign word_rd[g] = enable_flat[g*WORD_BITS +: WORD_BITS];
	end

	// Flat view drops the padding above the last interrupt
	assign irq_enable_o = enable_flat[NUM_IRQ-1:0];

	// Read side state: one data register
	typedef struct packed {
		logic [DATA_W-1:0] rdata; // Held for exactly one cycle
	} rd_state_s;

	rd_state_s state_q; // Registered state
	rd_state_s state_d; // Next state

	// Both views of a word show the same shared enable state
	always_comb begin
		state_d       = state_q;
		// Idle value unless a mapped read is taken this cycle
		state_d.rdata = RDATA_IDLE;
		if (rd_i && dec.hit) begin
			state_d.rdata = word_rd[dec.idx];
		end
	end

	// Register read data; idle value outside the answer cycle
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			state_q.rdata <= RDATA_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	assign rdata_o = state_q.rdata;

	// Checks on the register behaviour
	// Reset holds them off; a_reset_zero watches reset itself
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	// Write strobe aimed at one offset
	sequence s_write(logic [ADDR_W-1:0] ofs);
		wr_i && addr_i == ofs;
	endsequence

	// Read strobe aimed at one offset
	sequence s_read(logic [ADDR_W-1:0] ofs);
		rd_i && addr_i == ofs;
	endsequence

	a_set_word1_or: assert property (s_write(OFS_SET_WORD1) |=>
		irq_enable_o[31:0] == ($past(irq_enable_o[31:0]) | $past(wdata_i)))
		else $error("set word one did not OR in the written ones");

	a_clr_word1_and: assert property (s_write(OFS_CLR_WORD1) |=>
		irq_enable_o[31:0] == ($past(irq_enable_o[31:0]) & ~$past(wdata_i)))
		else $error("clear word one did not remove the written ones");

	a_set_word3_map: assert property (s_write(OFS_SET_WORD3) |=>
		irq_enable_o[78:64] == ($past(irq_enable_o[78:64]) | $past(wdata_i[14:0])))
		else $error("set word three maps to the wrong interrupts");

	a_clr_word1_keep: assert property (s_write(OFS_CLR_WORD1) |=>
		irq_enable_o[78:32] == $past(irq_enable_o[78:32]))
		else $error("clear word one touched interrupts above 31");

	// The sampled reset term keeps the edge that applies reset out of the check
	a_idle_holds: assert property (resetn_i && !wr_i |=> $stable(irq_enable_o))
		else $error("enable state moved without a write");

	a_read_clr_view: assert property (s_read(OFS_CLR_WORD1) |=>
		rdata_o == $past(irq_enable_o[31:0]))
		else $error("clear word one read is not the enable state");

	a_read_word3_pad: assert property (s_read(OFS_SET_WORD3) |=>
		rdata_o[31:15] == 17'h00000 && rdata_o[14:0] == $past(irq_enable_o[78:64]))
		else $error("set word three read has wrong bits");

	a_reset_zero: assert property (@(posedge ref_clk_i) disable iff (1'b0)
		!resetn_i |=> irq_enable_o == '0 && rdata_o == RDATA_IDLE)
		else $error("enable state not zero after reset");

	a_set_word2_or: assert property (s_write(OFS_SET_WORD2) |=>
		irq_enable_o[63:32] == ($past(irq_enable_o[63:32]) | $past(wdata_i)))
		else $error("set word two did not OR in the written ones");

	a_clr_word2_and: assert property (s_write(OFS_CLR_WORD2) |=>
		irq_enable_o[63:32] == ($past(irq_enable_o[63:32]) & ~$past(wdata_i)))
		else $error("clear word two did not remove the written ones");

	a_read_one_cycle: assert property (!rd_i |=> rdata_o == RDATA_IDLE)
		else $error("read data present outside the answer cycle");

	// Writes leave every interrupt outside the addressed word alone
	a_set_word1_keep: assert property (s_write(OFS_SET_WORD1) |=>
		irq_enable_o[78:32] == $past(irq_enable_o[78:32]))
		else $error("set word one touched interrupts above 31");

	a_set_word2_keep: assert property (s_write(OFS_SET_WORD2) |=>
		irq_enable_o[31:0] == $past(irq_enable_o[31:0]) &&
		irq_enable_o[78:64] == $past(irq_enable_o[78:64]))
		else $error("set word two touched interrupts outside its word");

	a_set_word3_keep: assert property (s_write(OFS_SET_WORD3) |=>
		irq_enable_o[63:0] == $past(irq_enable_o[63:0]))
		else $error("set word three touched interrupts below 64");

	a_clr_word3_keep: assert property (s_write(OFS_CLR_WORD3) |=>
		irq_enable_o[63:0] == $past(irq_enable_o[63:0]))
		else $error("clear word three touched interrupts below 64");

	// Clear word three removes only the fifteen implemented bits
	a_clr_word3_and: assert property (s_write(OFS_CLR_WORD3) |=>
		irq_enable_o[78:64] == ($past(irq_enable_o[78:64]) & ~$past(wdata_i[14:0])))
		else $error("clear word three did not remove the written ones");

	// A write of all zeros, to any word, changes nothing
	a_zero_write_keep: assert property (resetn_i && wr_i && wdata_i == '0 |=>
		$stable(irq_enable_o))
		else $error("a write of zeros moved the enable state");

	// Reads of the other views of the shared state
	a_read_set_view: assert property (s_read(OFS_SET_WORD1) |=>
		rdata_o == $past(irq_enable_o[31:0]))
		else $error("set word one read is not the enable state");

	a_read_word2_view: assert property (s_read(OFS_CLR_WORD2) |=>
		rdata_o == $past(irq_enable_o[63:32]))
		else $error("clear word two read is not the enable state");

	a_read_clr3_pad: assert property (s_read(OFS_CLR_WORD3) |=>
		rdata_o[31:15] == 17'h00000 && rdata_o[14:0] == $past(irq_enable_o[78:64]))
		else $error("clear word three read has wrong bits");

	// An address off the map answers with the idle value
	a_read_unmapped: assert property (rd_i && !dec.hit |=> rdata_o == RDATA_IDLE)
		else $error("read of an unmapped address returned data");

	// Ones written show through the other view on the very next read
	sequence s_set2_then_read;
		s_write(OFS_SET_WORD2) ##1 s_read(OFS_CLR_WORD2);
	endsequence

	a_write_read_seen: assert property (s_set2_then_read |=>
		(rdata_o & $past(wdata_i, 2)) == $past(wdata_i, 2))
		else $error("ones just written are missing from the next read");

	// Ones cleared are gone from the set view on the very next read
	sequence s_clr1_then_read;
		s_write(OFS_CLR_WORD1) ##1 s_read(OFS_SET_WORD1);
	endsequence

	a_clear_read_gone: assert property (s_clr1_then_read |=>
		(rdata_o & $past(wdata_i, 2)) == '0)
		else $error("ones just cleared still show on the next read");

endmodule : irq_enable_regs

// >>> core/irq_word_if.sv
// Interface carrying set and clear masks to one enable word and its state back
`timescale 1ns/1ps
interface irq_word_if #(
	parameter int unsigned W = 32 // Bits in this word
);
	logic [W-1:0] set_bits;   // One-cycle mask of bits to enable
	logic [W-1:0] clear_bits; // One-cycle mask of bits to disable
	logic [W-1:0] enable;     // Current enable state

	modport ctrl (output set_bits, output clear_bits, input enable);
	modport bank (input set_bits, input clear_bits, output enable);
endinterface : irq_word_if

// >>> dv/tb.sv
// Self-checking bench for the interrupt enable set/clear register block
`timescale 1ns/1ps
module tb
	import irq_enable_pkg::*;
;
	typedef struct packed {
		logic [ADDR_W-1:0] wa; // Write address
		logic [DATA_W-1:0] wd; // Write data
		logic [ADDR_W-1:0] ra; // Read-back address
		logic [DATA_W-1:0] re; // Expected read-back data
	} row_s;

	logic               ref_clk_i = 1'b0; // Core clock
	logic               resetn_i  = 1'b0; // Reset, active low
	logic [ADDR_W-1:0]  addr_i    = '0;   // Bus address
	logic [DATA_W-1:0]  wdata_i   = '0;   // Bus write data
	logic               wr_i      = 1'b0; // Write strobe
	logic               rd_i      = 1'b0; // Read strobe
	logic [DATA_W-1:0]  rdata_o;          // Read data
	logic [NUM_IRQ-1:0] irq_enable_o;     // Enable state
	logic [NUM_IRQ-1:0] exp_en = '0;      // Expected enable state
	int                 n_errors = 0;     // Mismatch count
	int                 checks   = 0;     // Comparison count
	row_s               rows [9];         // Ordinary cases

	irq_enable_regs u_irq_enable_regs (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .irq_enable_o(irq_enable_o));

	// 25 MHz clock
	initial begin
		forever #20 ref_clk_i = ~ref_clk_i;
	end

	// Word-level model; upper padding bits fall away on return, so word three keeps 15 bits
	function automatic logic [NUM_IRQ-1:0] upd(logic [NUM_IRQ-1:0] c, row_s r);
		logic [95:0] w;
		w = {17'h0, c};
		case (r.wa)
			OFS_SET_WORD1: w[31:0]  = w[31:0] | r.wd;
			OFS_SET_WORD2: w[63:32] = w[63:32] | r.wd;
			OFS_SET_WORD3: w[95:64] = w[95:64] | r.wd;
			OFS_CLR_WORD1: w[31:0]  = w[31:0] & ~r.wd;
			OFS_CLR_WORD2: w[63:32] = w[63:32] & ~r.wd;
			OFS_CLR_WORD3: w[95:64] = w[95:64] & ~r.wd;
			default:       w = w; // Unmapped: no effect
		endcase
		return w[NUM_IRQ-1:0];
	endfunction : upd

	// Read value expected at an address; set and clear words share state
	function automatic logic [DATA_W-1:0] rexp(logic [NUM_IRQ-1:0] c, logic [ADDR_W-1:0] a);
		logic [95:0] w;
		w = {17'h0, c};
		case (a)
			OFS_SET_WORD1, OFS_CLR_WORD1: return w[31:0];
			OFS_SET_WORD2, OFS_CLR_WORD2: return w[63:32];
			OFS_SET_WORD3, OFS_CLR_WORD3: return w[95:64];
			default:                      return RDATA_IDLE;
		endcase
	endfunction : rexp

	// One comparison; four-state equality so an X matches only an X
	task automatic chk(input logic [NUM_IRQ-1:0] seen, input logic [NUM_IRQ-1:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Single-cycle write
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge ref_clk_i);
		wr_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge ref_clk_i);
		wr_i    <= 1'b0;
	endtask : wr

	// Read; data only in the cycle after the strobe, idle zero after that
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge ref_clk_i);
		rd_i   <= 1'b1;
		addr_i <= a;
		@(posedge ref_clk_i);
		rd_i   <= 1'b0;
		#1 chk(rdata_o, e);
		@(posedge ref_clk_i);
		#1 chk(rdata_o, RDATA_IDLE);
	endtask : rd

	// Verdict, reached by the tests or the watchdog
	task automatic wrap_up();
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : wrap_up

	// Watchdog; the tests need well under 300 cycles
	initial begin
		repeat (2000) @(posedge ref_clk_i);
		n_errors++;
		wrap_up();
	end

	// Main sequence
	initial begin
		rows = '{
			'{OFS_SET_WORD1, 32'hFFFFFFFF, OFS_CLR_WORD1, 32'hFFFFFFFF},
			'{OFS_CLR_WORD1, 32'h80000005, OFS_SET_WORD1, 32'h7FFFFFFA},
			'{OFS_CLR_WORD1, 32'h00000000, OFS_CLR_WORD1, 32'h7FFFFFFA},
			'{OFS_SET_WORD2, 32'h80000001, OFS_CLR_WORD2, 32'h80000001},
			'{OFS_CLR_WORD2, 32'h80000000, OFS_SET_WORD2, 32'h00000001},
			'{OFS_SET_WORD3, 32'hFFFFFFFF, OFS_SET_WORD3, 32'h00007FFF},
			'{OFS_CLR_WORD3, 32'hFFFF4001, OFS_CLR_WORD3, 32'h00003FFE},
			'{8'h20,         32'hFFFFFFFF, 8'h20,         32'h00000000},
			'{OFS_SET_WORD1, 32'h00000000, OFS_SET_WORD1, 32'h7FFFFFFA}};
		repeat (8) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		#1 chk(irq_enable_o, '0);
		rd(OFS_SET_WORD3, 32'h00000000);
		$display("reset test done");
		// Table of writes, each followed by a read-back
		foreach (rows[i]) begin
			wr(rows[i].wa, rows[i].wd);
			exp_en = upd(exp_en, rows[i]);
			#1 chk(irq_enable_o, exp_en);
			rd(rows[i].ra, rows[i].re);
			$display("row %0d done", i);
		end
		// Back-to-back write then read of the same word
		@(posedge ref_clk_i);
		wr_i    <= 1'b1;
		addr_i  <= OFS_SET_WORD2;
		wdata_i <= 32'h00F00000;
		@(posedge ref_clk_i);
		wr_i    <= 1'b0;
		rd_i    <= 1'b1;
		addr_i  <= OFS_CLR_WORD2;
		@(posedge ref_clk_i);
		rd_i    <= 1'b0;
		wr_i    <= 1'b1;
		addr_i  <= OFS_CLR_WORD1;
		wdata_i <= 32'h0000FFFF;
		exp_en[55:52] = 4'hF;
		#1 chk(rdata_o, rexp(exp_en, OFS_SET_WORD2));
		chk(irq_enable_o, exp_en);
		// Clear then read through the set view, again with no gap
		@(posedge ref_clk_i);
		wr_i    <= 1'b0;
		rd_i    <= 1'b1;
		addr_i  <= OFS_SET_WORD1;
		exp_en[15:0] = '0;
		#1 chk(irq_enable_o, exp_en);
		@(posedge ref_clk_i);
		rd_i    <= 1'b0;
		#1 chk(rdata_o, 32'h7FFF0000);
		$display("back-to-back done");
		// Reset in mid-run drops every enable
		@(posedge ref_clk_i);
		resetn_i <= 1'b0;
		@(posedge ref_clk_i);
		resetn_i <= 1'b1;
		#1 chk(irq_enable_o, '0);
		chk(rdata_o, RDATA_IDLE);
		// First write after the release; bits above 14 of word three fall away
		exp_en = '0;
		wr(OFS_SET_WORD3, 32'hFFFF8001);
		exp_en[64] = 1'b1;
		#1 chk(irq_enable_o, exp_en);
		rd(OFS_CLR_WORD3, 32'h00000001);
		$display("mid-run reset done");
		wrap_up();
	end
endmodule : tb
